// *** pef_pkg.sv ***
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pef_pkg;

   localparam int PE_W = 16;
   localparam int PF_W = 8;

   // Register indices; the byte address is four times the index
   localparam logic [31:0] PE_DATA_IDX = 32'hffff83b0;
   localparam logic [31:0] PF_LEVEL_IDX = 32'hffff83b3;
   localparam logic [31:0] PE_DATA_ADDR = {PE_DATA_IDX[29:0], 2'h0};
   localparam logic [31:0] PF_LEVEL_ADDR = {PF_LEVEL_IDX[29:0], 2'h0};

   localparam logic [15:0] PE_DATA_RST = 16'h0000;
   localparam logic [15:0] PE_PIN_RST = 16'h0000;
   localparam logic [31:0] PRDATA_RST = 32'h00000000;
   localparam logic [7:0] PF_SAMPLE_LEVEL = 8'hff;

   // Pins whose alternate functions exist only in extended modes
   localparam logic [15:0] PE_EXT_ONLY_MASK = 16'h400f;

   typedef enum logic [1:0] {
      PEF_IDLE = 2'h1,
      PEF_ACCESS = 2'h2
   } pef_apb_state_t;

endpackage : pef_pkg

// *** pef_pin_if.sv ***
`timescale 1ns/1ps
interface pef_pin_if;
   logic [15:0] data;
   logic [15:0] dir;
   logic [15:0] alt_sel;
   logic [15:0] alt_out;
   logic [15:0] alt_oe;
   logic [15:0] pin_o;
   logic [15:0] pin_oe;

   modport core (
      output data,
      output dir,
      output alt_sel,
      output alt_out,
      output alt_oe,
      input pin_o,
      input pin_oe
   );

   modport mux (
      input data,
      input dir,
      input alt_sel,
      input alt_out,
      input alt_oe,
      output pin_o,
      output pin_oe
   );
endinterface : pef_pin_if

// *** pef_sync.sv ***
`timescale 1ns/1ps
module pef_sync #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   //---------------------------------------------------------------------------
   // Two-stage synchroniser; first stage feeds only the second
   //---------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta <= '0;
         q_o <= '0;
      end else if (ce_i) begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : pef_sync

// *** pef_pin_mux.sv ***
`timescale 1ns/1ps
module pef_pin_mux (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   pef_pin_if.mux p
);
   logic [15:0] next_pin_o;
   logic [15:0] next_pin_oe;
   logic [15:0] pin_q;
   logic [15:0] oe_q;

   //---------------------------------------------------------------------------
   // Per-pin selection of alternate function or general data
   //---------------------------------------------------------------------------
   for (genvar i = 0; i < pef_pkg::PE_W; i++) begin : g_pin
      assign next_pin_oe[i] = p.alt_sel[i] ? p.alt_oe[i] : p.dir[i];
      assign next_pin_o[i] = p.alt_sel[i] ? p.alt_out[i] : (p.dir[i] & p.data[i]);
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_q <= pef_pkg::PE_PIN_RST;
         oe_q <= pef_pkg::PE_PIN_RST;
      end else if (ce_i) begin
         pin_q <= next_pin_o;
         oe_q <= next_pin_oe;
      end
   end

   assign p.pin_o = pin_q;
   assign p.pin_oe = oe_q;
endmodule : pef_pin_mux

// *** pef_port_ef.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module pef_port_ef (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic single_chip_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // First port control from pin-control block
   input wire logic [15:0] pe_dir_i,
   input wire logic [15:0] pe_alt_sel_i,
   input wire logic [15:0] pe_alt_ext_i,
   input wire logic [15:0] pe_alt_out_i,
   input wire logic [15:0] pe_alt_oe_i,
   // First port pins
   input wire logic [15:0] pe_pin_i,
   output logic [15:0] pe_pin_o,
   output logic [15:0] pe_pin_oe_o,
   output logic [15:0] pe_pin_level_o,
   // Second port pins and converter state
   input wire logic [7:0] pf_pin_i,
   input wire logic [7:0] pf_sampling_i,
   output logic [7:0] pf_pin_level_o
);
   pef_pkg::pef_apb_state_t state;
   pef_pkg::pef_apb_state_t next_state;
   logic [15:0] pe_data;
   logic [15:0] next_pe_data;
   logic [15:0] pe_sync_q;
   logic [7:0] pf_sync_q;
   logic [31:0] next_prdata;
   logic [31:0] prdata_q;

   pef_pin_if pin_bus ();

   //---------------------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------------------
   pef_sync #(
      .W(pef_pkg::PE_W)
   ) u_pe_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .d_i(pe_pin_i),
      .q_o(pe_sync_q)
   );

   pef_sync #(
      .W(pef_pkg::PF_W)
   ) u_pf_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .d_i(pf_pin_i),
      .q_o(pf_sync_q)
   );

   assign pe_pin_level_o = pe_sync_q;
   assign pf_pin_level_o = pf_sync_q;

   //---------------------------------------------------------------------------
   // APB decode
   //---------------------------------------------------------------------------
   wire setup_ph = psel_i & ~penable_i;
   wire access_ph = psel_i & penable_i;
   wire in_idle = (state == pef_pkg::PEF_IDLE);
   wire in_access = (state == pef_pkg::PEF_ACCESS);
   wire hit_pe = (paddr_i == pef_pkg::PE_DATA_ADDR);
   wire hit_pf = (paddr_i == pef_pkg::PF_LEVEL_ADDR);
   wire unmapped = ~hit_pe & ~hit_pf;
   wire take_read = in_idle & setup_ph & ~pwrite_i & ce_i;
   wire done = in_access & access_ph & ce_i;
   wire pe_wr = done & pwrite_i & hit_pe;
   wire pf_wr = done & pwrite_i & hit_pf;

   // Alternate functions that exist only in extended modes fall back to general use in single-chip mode
   wire [15:0] alt_blocked = {16{single_chip_i}} & pe_alt_ext_i & pef_pkg::PE_EXT_ONLY_MASK;
   wire [15:0] alt_eff = pe_alt_sel_i & ~alt_blocked;

   // Direction 1 reads stored bit, direction 0 reads pin level
   wire [15:0] pe_read = (pe_dir_i & pe_data) | (~pe_dir_i & pe_sync_q);
   // Sampled channels read as ones
   wire [7:0] pf_read = (pf_sync_q & ~pf_sampling_i) | (pef_pkg::PF_SAMPLE_LEVEL & pf_sampling_i);

   always_comb begin
      next_state = state;
      case (state)
         pef_pkg::PEF_IDLE: begin
            if (setup_ph) begin
               next_state = pef_pkg::PEF_ACCESS;
            end
         end
         pef_pkg::PEF_ACCESS: begin
            if (access_ph) begin
               next_state = pef_pkg::PEF_IDLE;
            end
         end
         default: begin
            next_state = pef_pkg::PEF_IDLE;
         end
      endcase
   end

   always_comb begin
      next_prdata = 32'h00000000;
      if (hit_pe) begin
         next_prdata = {16'h0000, pe_read};
      end else if (hit_pf) begin
         next_prdata = {24'h000000, pf_read};
      end
   end

   //---------------------------------------------------------------------------
   // First port data register with byte strobes
   //---------------------------------------------------------------------------
   for (genvar b = 0; b < 2; b++) begin : g_lane
      assign next_pe_data[b*8 +: 8] = (pe_wr & pstrb_i[b]) ? pwdata_i[b*8 +: 8]
                                                         : pe_data[b*8 +: 8];
   end

   // Only the power-on reset clears the stored data
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pe_data <= pef_pkg::PE_DATA_RST;
      end else if (ce_i) begin
         pe_data <= next_pe_data;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= pef_pkg::PEF_IDLE;
      end else if (ce_i) begin
         state <= next_state;
      end
   end

   // Read data is taken at the setup edge and stands until the next read setup
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_q <= pef_pkg::PRDATA_RST;
      end else if (take_read) begin
         prdata_q <= next_prdata;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = ce_i;
   assign pslverr_o = in_access & access_ph & unmapped;

   //---------------------------------------------------------------------------
   // Pin drive
   //---------------------------------------------------------------------------
   assign pin_bus.data = pe_data;
   assign pin_bus.dir = pe_dir_i;
   assign pin_bus.alt_sel = alt_eff;
   assign pin_bus.alt_out = pe_alt_out_i;
   assign pin_bus.alt_oe = pe_alt_oe_i;

   pef_pin_mux u_pin_mux (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .p(pin_bus.mux)
   );

   assign pe_pin_o = pin_bus.pin_o;
   assign pe_pin_oe_o = pin_bus.pin_oe;

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   AST_PE_RD_STORED: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      take_read & hit_pe |=> ((prdata_o[15:0] ^ $past(pe_data)) & $past(pe_dir_i)) == 16'h0000
   ) else $error("Output-direction bit did not read stored data");

   AST_PE_RD_PIN: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      take_read & hit_pe |=> ((prdata_o[15:0] ^ $past(pe_sync_q)) & ~$past(pe_dir_i)) == 16'h0000
   ) else $error("Input-direction bit did not read pin level");

   AST_PE_WRITE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      pe_wr & (pstrb_i[1:0] == 2'h3) |=> pe_data == $past(pwdata_i[15:0])
   ) else $error("Full write did not land in data register");

   AST_PE_HOLD: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !pe_wr |=> $stable(pe_data)
   ) else $error("Data register changed without a write");

   AST_PF_WR_DROP: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      pf_wr |-> !pslverr_o ##1 $stable(pe_data)
   ) else $error("Second port write had an effect");

   AST_PF_SAMPLE_ONE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      take_read & hit_pf |=> (prdata_o[7:0] & $past(pf_sampling_i)) == $past(pf_sampling_i)
   ) else $error("Sampled channel did not read as one");

   AST_PF_LEVEL: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      take_read & hit_pf |=> ((prdata_o[7:0] ^ $past(pf_sync_q)) & ~$past(pf_sampling_i)) == 8'h00
         && prdata_o[31:8] == 24'h000000
   ) else $error("Second port read did not show pin level");

   AST_PE_DRIVE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      resetn_i & ce_i |=> ((pe_pin_o ^ $past(pe_data)) & $past(pe_dir_i & ~alt_eff)) == 16'h0000
         && (~pe_pin_oe_o & $past(pe_dir_i & ~alt_eff)) == 16'h0000
   ) else $error("General output pin not driving stored bit");

   AST_PE_INPUT_QUIET: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i |=> (pe_pin_oe_o & $past(~pe_dir_i & ~alt_eff)) == 16'h0000
   ) else $error("General input pin is driven");

   AST_SC_BLOCK: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      resetn_i & ce_i & single_chip_i |=> ((pe_pin_oe_o ^ $past(pe_dir_i))
         & $past(pe_alt_sel_i & pe_alt_ext_i & pef_pkg::PE_EXT_ONLY_MASK)) == 16'h0000
   ) else $error("Extended-only function reached a pin in single-chip mode");

   AST_APB_ONE_WAIT: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      in_idle & setup_ph & ce_i ##1 access_ph & ce_i |-> pready_o ##1 in_idle
   ) else $error("Transfer did not complete in its access cycle");

   //---------------------------------------------------------------------------
   // Reset, enable, synchroniser, transfer state, read data and alternate drive checks
   //---------------------------------------------------------------------------
   // Pin checks skip the release edge itself, where the flops still clear
   AST_PE_POR_CLEAR: assert property (
      @(posedge clk_i)
      !resetn_i |=> pe_data == pef_pkg::PE_DATA_RST
   ) else $error("Data register not cleared by power-on reset");

   AST_PIN_RESET: assert property (
      @(posedge clk_i)
      !resetn_i |=> pe_pin_oe_o == pef_pkg::PE_PIN_RST && pe_pin_o == pef_pkg::PE_PIN_RST
   ) else $error("Pins not released during reset");

   AST_CE_FREEZE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !ce_i |=> $stable(pe_data) && $stable(state) && $stable(prdata_o)
         && $stable(pe_pin_o) && $stable(pe_pin_oe_o) && $stable(pf_pin_level_o)
   ) else $error("State moved while the clock enable was low");

   AST_STATE_ONEHOT: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      $onehot(state)
   ) else $error("Transfer state left its one-hot codes");

   AST_SETUP_TO_ACCESS: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      in_idle & setup_ph & ce_i |=> in_access
   ) else $error("Setup cycle did not lead to the access cycle");

   AST_PE_RD_UPPER: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      take_read & hit_pe |=> prdata_o[31:16] == 16'h0000
   ) else $error("First port read drove the upper half");

   AST_UNMAPPED_ZERO: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      take_read & unmapped |=> prdata_o == 32'h00000000
   ) else $error("Unmapped read returned data");

   AST_ERR_DECODE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      in_idle & setup_ph & ce_i ##1 access_ph |-> pslverr_o == unmapped
   ) else $error("Error response did not match the address decode");

   AST_PRDATA_HOLD: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !take_read |=> $stable(prdata_o)
   ) else $error("Read data changed outside a read setup");

   AST_PE_ALT_DRIVE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      resetn_i & ce_i |=> ((pe_pin_o ^ $past(pe_alt_out_i)) & $past(alt_eff)) == 16'h0000
         && ((pe_pin_oe_o ^ $past(pe_alt_oe_i)) & $past(alt_eff)) == 16'h0000
   ) else $error("Alternate function did not reach its pin");

   AST_PE_SYNC: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      resetn_i & ce_i ##1 ce_i |=> pe_pin_level_o == $past(pe_pin_i, 2)
   ) else $error("First port level did not follow its pin");

   AST_PF_SYNC: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      resetn_i & ce_i ##1 ce_i |=> pf_pin_level_o == $past(pf_pin_i, 2)
   ) else $error("Second port level did not follow its pin");

endmodule : pef_port_ef

// *** pef_apb_host.sv ***
`timescale 1ns/1ps
module pef_apb_host (
   input wire logic clk_i,
   input wire logic pready_i,
   input wire logic [31:0] prdata_i,
   input wire logic pslverr_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [31:0] paddr_o,
   output logic [31:0] pwdata_o,
   output logic [3:0] pstrb_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 32'h00000000;
      pwdata_o = 32'h00000000;
      pstrb_o = 4'h0;
   end

   // ----------------------------------------
   // One transfer: setup, then access until ready
   // ----------------------------------------
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= wr;
      paddr_o <= addr;
      pwdata_o <= wdata;
      pstrb_o <= (addr == pef_pkg::PF_LEVEL_ADDR) ? 4'h1 : 4'h3;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      rdata = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Released bus no longer shows the last address and write data
      paddr_o <= ~addr;
      pwdata_o <= ~wdata;
   endtask : xfer
endmodule : pef_apb_host

// *** pef_port_ef_bench.sv ***
`timescale 1ns/1ps
module pef_port_ef_bench;
   localparam logic [31:0] EA = pef_pkg::PE_DATA_ADDR;
   localparam logic [31:0] FA = pef_pkg::PF_LEVEL_ADDR;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic single_chip = 1'b0;
   logic [15:0] dir = 16'hffff;
   logic [15:0] alt_sel = 16'h0000;
   logic [15:0] alt_ext = 16'h0000;
   logic [15:0] alt_out = 16'h0000;
   logic [15:0] alt_oe = 16'h0000;
   logic [15:0] ext_drv = 16'h0000;
   logic [7:0] pf_pin = 8'h00;
   logic [7:0] sampling = 8'h00;
   logic [15:0] pin_o, pin_oe, pe_lvl, pe_pin;
   logic [7:0] pf_lvl;
   logic psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, d;
   logic [3:0] pstrb;
   logic e;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   // Wire level: driven bits from the design, the rest from the outside driver
   assign pe_pin = (pin_oe & pin_o) | (~pin_oe & ext_drv);

   pef_apb_host host (.clk_i(clk), .pready_i(pready), .prdata_i(prdata),
      .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));

   pef_port_ef dut (.clk_i(clk), .resetn_i(resetn), .ce_i(ce), .single_chip_i(single_chip),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pe_dir_i(dir), .pe_alt_sel_i(alt_sel), .pe_alt_ext_i(alt_ext),
      .pe_alt_out_i(alt_out), .pe_alt_oe_i(alt_oe), .pe_pin_i(pe_pin), .pe_pin_o(pin_o),
      .pe_pin_oe_o(pin_oe), .pe_pin_level_o(pe_lvl), .pf_pin_i(pf_pin),
      .pf_sampling_i(sampling), .pf_pin_level_o(pf_lvl));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      host.xfer(1'b1, addr, data, d, e);
   endtask : wr

   task automatic rd(input string what, input logic [31:0] addr, input logic [31:0] exp);
      host.xfer(1'b0, addr, 32'h00000000, d, e);
      check(what, d, exp);
   endtask : rd

   task automatic test_done();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         test_done();
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd("reset value", EA, 32'h00000000);
      wr(EA, 32'h0000a5c3);
      rd("output readback", EA, 32'h0000a5c3);
      check("pin drive", {16'h0000, pin_o}, 32'h0000a5c3);
      check("pin enable", {16'h0000, pin_oe}, 32'h0000ffff);
      $display("test general output done");
      @(posedge clk);
      dir <= 16'h00ff;
      ext_drv <= 16'h3c00;
      repeat (4) @(posedge clk);
      rd("input readback", EA, 32'h00003cc3);
      check("pin level", {16'h0000, pe_lvl}, 32'h00003cc3);
      wr(EA, 32'h00001234);
      rd("write to inputs", EA, 32'h00003c34);
      check("input pins released", {16'h0000, pin_oe}, 32'h000000ff);
      @(posedge clk);
      dir <= 16'hffff;
      rd("stored value", EA, 32'h00001234);
      $display("test general input done");
      @(posedge clk);
      alt_sel <= 16'hffff;
      alt_out <= 16'h5555;
      alt_oe <= 16'hffff;
      wr(EA, 32'h00000f0f);
      rd("alternate dir1", EA, 32'h00000f0f);
      check("alternate drive", {16'h0000, pin_o}, 32'h00005555);
      @(posedge clk);
      single_chip <= 1'b1;
      alt_ext <= 16'h400f;
      repeat (3) @(posedge clk);
      check("single chip fallback", {16'h0000, pin_o}, 32'h0000155f);
      @(posedge clk);
      dir <= 16'h0000;
      single_chip <= 1'b0;
      repeat (4) @(posedge clk);
      rd("alternate dir0", EA, 32'h00005555);
      $display("test alternate done");
      @(posedge clk);
      ce <= 1'b0;
      dir <= 16'hffff;
      alt_sel <= 16'h0000;
      repeat (4) @(posedge clk);
      check("frozen pins", {16'h0000, pin_o}, 32'h00005555);
      check("ready while frozen", {31'h0, pready}, 32'h00000000);
      @(posedge clk);
      ce <= 1'b1;
      rd("retained", EA, 32'h00000f0f);
      $display("test retention done");
      @(posedge clk);
      pf_pin <= 8'h5a;
      sampling <= 8'h03;
      repeat (4) @(posedge clk);
      rd("sampled bits", FA, 32'h0000005b);
      wr(FA, 32'h000000ff);
      rd("write ignored", FA, 32'h0000005b);
      @(posedge clk);
      sampling <= 8'h00;
      rd("live levels", FA, 32'h0000005a);
      check("port f level", {24'h000000, pf_lvl}, 32'h0000005a);
      host.xfer(1'b0, EA + 32'h00000010, 32'h00000000, d, e);
      check("unmapped error", {31'h0, e}, 32'h00000001);
      check("unmapped data", d, 32'h00000000);
      $display("test port f done");
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd("power on clear", EA, 32'h00000000);
      rd("levels after reset", FA, 32'h0000005a);
      $display("test reset done");
      test_done();
   end
endmodule : pef_port_ef_bench
